// >>> spilp_pkg.sv
package spilp_pkg;
  localparam logic [7:0] SPILP_CR1_OFS  = 8'h00;
  localparam logic [7:0] SPILP_CR2_OFS  = 8'h04;
  localparam logic [7:0] SPILP_SR_OFS   = 8'h08;
  localparam logic [7:0] SPILP_DR_OFS   = 8'h0C;
  localparam logic [7:0] SPILP_CTRL_OFS = 8'h10;
  // Control register one and two bit positions
  localparam int SPILP_CR1_TEIE  = 5;
  localparam int SPILP_CR1_EN    = 6;
  localparam int SPILP_CR1_DIE   = 7;
  localparam int SPILP_CR1_MASTER_SELECT_BIT  = 4;
  localparam int SPILP_CR1_MFIE  = 3;
  localparam int SPILP_CR1_MFEN  = 2;
  localparam int SPILP_CR2_SWAI  = 1;
  // Status bit positions
  localparam int SPILP_SR_DONE   = 7;
  localparam int SPILP_SR_TXE    = 5;
  localparam int SPILP_SR_MODE_FAULT_FLAG   = 4;
  // Power control register bit positions
  localparam int SPILP_CTRL_WAIT = 0;
  localparam int SPILP_CTRL_STOP = 1;
  localparam logic [7:0] SPILP_CR1_RST = 8'h00;
  localparam logic [7:0] SPILP_CR2_RST = 8'h00;
  localparam logic [7:0] SPILP_DR_RST  = 8'h00;
  localparam logic [3:0] SPILP_BITS    = 4'h8;
  localparam logic [7:0] SPILP_HALF_DIV = 8'h04;
  localparam logic [1:0] SPILP_RESP_OK  = 2'h0;
  localparam logic [1:0] SPILP_RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    SPILP_IDLE  = 2'b00,
    SPILP_SHIFT = 2'b01,
    SPILP_DONE  = 2'b10
  } spilp_state_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spilp_pins_t;
endpackage

// >>> spilp_core.sv
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module spilp_core (
  input  wire logic                 aclk,          // Bus clock
  input  wire logic                 aresetn,       // Synchronous reset, low
  input  wire logic [7:0]           s_axi_awaddr,  // Write address
  input  wire logic                 s_axi_awvalid, // Write address valid
  output logic                      s_axi_awready, // Write address ready
  input  wire logic [31:0]          s_axi_wdata,   // Write data
  input  wire logic [3:0]           s_axi_wstrb,   // Byte enables
  input  wire logic                 s_axi_wvalid,  // Write data valid
  output logic                      s_axi_wready,  // Write data ready
  output logic [1:0]                s_axi_bresp,   // Write response
  output logic                      s_axi_bvalid,  // Write response valid
  input  wire logic                 s_axi_bready,  // Write response ready
  input  wire logic [7:0]           s_axi_araddr,  // Read address
  input  wire logic                 s_axi_arvalid, // Read address valid
  output logic                      s_axi_arready, // Read address ready
  output logic [31:0]               s_axi_rdata,   // Read data
  output logic [1:0]                s_axi_rresp,   // Read response
  output logic                      s_axi_rvalid,  // Read data valid
  input  wire logic                 s_axi_rready,  // Read data ready
  input  wire logic                 sck_i,         // Serial clock pin in
  input  wire logic                 mosi_i,        // Master-out pin in
  input  wire logic                 miso_i,        // Master-in pin in
  input  wire logic                 ss_n_i,        // Slave select, low
  output spilp_pkg::spilp_pins_t    pins,          // Pin drive and enables
  output logic                      irq            // Shared interrupt, high
);
  import spilp_pkg::*;

  logic [7:0]   cr1_q, cr2_q, dr_q, txbuf_q, sh_q;
  logic         txfull_q, done_q, txe_q, mode_fault_flag_q, mode_fault_flag_seen_q;
  logic         wait_q, stop_q, pend_q;
  logic [2:0]   sck_s, ss_s;
  logic [1:0]   mosi_s, miso_s;
  logic [3:0]   bit_q;
  logic [7:0]   div_q;
  logic         msck_q, lat_q;
  spilp_state_t st_q;
  logic         aw_q, w_q;
  logic [7:0]   awa_q;
  logic [31:0]  wd_q;

  wire master   = cr1_q[SPILP_CR1_MASTER_SELECT_BIT];
  wire enabled  = cr1_q[SPILP_CR1_EN];
  // Stop acts like wait with stop-on-wait set
  wire frozen   = stop_q | (wait_q & cr2_q[SPILP_CR2_SWAI]);
  wire sin      = master ? miso_s[1] : mosi_s[1];
  wire sck_rise = sck_s[1] & ~sck_s[2];
  wire sck_fall = ~sck_s[1] & sck_s[2];
  wire ss_low   = ~ss_s[1];

  // Two-stage synchronisers; stage two feeds logic, stage three only for edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_s  <= 3'h0;
      ss_s   <= 3'h7;
      mosi_s <= 2'h0;
      miso_s <= 2'h0;
    end else begin
      sck_s  <= {sck_s[1:0], sck_i};
      ss_s   <= {ss_s[1:0], ss_n_i};
      mosi_s <= {mosi_s[0], mosi_i};
      miso_s <= {miso_s[0], miso_i};
    end
  end

  // Register bus
  wire wr_go = aw_q & w_q & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
  wire mfault = enabled & master & cr1_q[SPILP_CR1_MFEN] & ss_low;
  wire cr1_wr = wr_go && awa_q == SPILP_CR1_OFS;
  wire dr_wr  = wr_go && awa_q == SPILP_DR_OFS;
  wire sr_rd  = rd_go && s_axi_araddr == SPILP_SR_OFS;
  wire dr_rd  = rd_go && s_axi_araddr == SPILP_DR_OFS;
  wire start  = (st_q == SPILP_IDLE) & txfull_q & enabled & master & ~frozen & ~mfault;
  wire slv_go = (st_q == SPILP_IDLE) & enabled & ~master & ss_low;
  wire last   = (st_q == SPILP_SHIFT) & (bit_q == SPILP_BITS) & ~lat_q;
  wire finish = (st_q == SPILP_DONE) & ~(frozen & ~master);

  assign s_axi_awready = ~aw_q;
  assign s_axi_wready  = ~w_q;
  assign s_axi_arready = ~s_axi_rvalid;
  assign s_axi_bresp   = SPILP_RESP_OK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q  <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q  <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q  <= 1'b1;
        wd_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= SPILP_RESP_OK;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= SPILP_RESP_OK;
      case (s_axi_araddr)
        SPILP_CR1_OFS:  s_axi_rdata <= {24'h0, cr1_q};
        SPILP_CR2_OFS:  s_axi_rdata <= {24'h0, cr2_q};
        SPILP_SR_OFS:   s_axi_rdata <= {24'h0, done_q, 1'b0, txe_q, mode_fault_flag_q, 4'h0};
        SPILP_DR_OFS:   s_axi_rdata <= {24'h0, dr_q};
        SPILP_CTRL_OFS: s_axi_rdata <= {30'h0, stop_q, wait_q};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= SPILP_RESP_ERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Control and power registers; mode fault clears the master bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cr1_q  <= SPILP_CR1_RST;
      cr2_q  <= SPILP_CR2_RST;
      wait_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (cr1_wr)
        cr1_q <= wd_q[7:0];
      if (wr_go && awa_q == SPILP_CR2_OFS)
        cr2_q <= wd_q[7:0];
      if (wr_go && awa_q == SPILP_CTRL_OFS) begin
        wait_q <= wd_q[SPILP_CTRL_WAIT];
        stop_q <= wd_q[SPILP_CTRL_STOP];
      end
      if (mfault)
        cr1_q[SPILP_CR1_MASTER_SELECT_BIT] <= 1'b0;
    end
  end

  // Transmit buffer; stale byte may go out before first write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txbuf_q  <= SPILP_DR_RST;
      txfull_q <= 1'b0;
    end else begin
      if (dr_wr) begin
        txbuf_q  <= wd_q[7:0];
        txfull_q <= 1'b1;
      end else if (start || slv_go) begin
        txfull_q <= 1'b0;
      end
    end
  end

  // Shift engine: frozen master holds state, slave follows external clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= SPILP_IDLE;
      sh_q   <= 8'h00;
      bit_q  <= 4'h0;
      div_q  <= 8'h00;
      msck_q <= 1'b0;
      lat_q  <= 1'b0;
    end else begin
      case (st_q)
        SPILP_IDLE: begin
          if (start || slv_go) begin
            st_q  <= SPILP_SHIFT;
            // Slave with no new byte echoes what it last received
            sh_q  <= txfull_q ? txbuf_q : sh_q;
            bit_q <= 4'h0;
            div_q <= 8'h00;
            lat_q <= 1'b0;
          end
        end
        SPILP_SHIFT: begin
          if (mfault) begin
            st_q   <= SPILP_IDLE;
            msck_q <= 1'b0;
          end else if (last) begin
            st_q <= SPILP_DONE;
            msck_q <= 1'b0;
          end else if (master) begin
            if (!frozen) begin
              if (div_q == SPILP_HALF_DIV - 8'h01) begin
                div_q  <= 8'h00;
                msck_q <= ~msck_q;
                if (!msck_q) begin
                  lat_q <= 1'b1;
                  sh_q  <= {sh_q[6:0], sin};
                  bit_q <= bit_q + 4'h1;
                end else begin
                  lat_q <= 1'b0;
                end
              end else begin
                div_q <= div_q + 8'h01;
              end
            end
          end else begin
            if (sck_rise) begin
              lat_q <= 1'b1;
              sh_q  <= {sh_q[6:0], sin};
              bit_q <= bit_q + 4'h1;
            end else if (sck_fall || (bit_q == SPILP_BITS && lat_q)) begin
              lat_q <= 1'b0;
            end
            if (ss_s[1])
              st_q <= SPILP_IDLE;
          end
        end
        SPILP_DONE: begin
          if (finish)
            st_q <= SPILP_IDLE;
        end
        default: st_q <= SPILP_IDLE;
      endcase
    end
  end

  // Completion: done flag and data copy, skipped if flag still pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dr_q   <= SPILP_DR_RST;
      done_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      if (sr_rd && done_q)
        pend_q <= 1'b1;
      if (finish && !done_q) begin
        done_q <= 1'b1;
        dr_q   <= sh_q;
      end else if (dr_rd && pend_q) begin
        done_q <= 1'b0;
        pend_q <= 1'b0;
      end
    end
  end

  // Tx empty set wins over its clear by a data write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txe_q <= 1'b1;
    end else if (start || slv_go) begin
      txe_q <= 1'b1;
    end else if (dr_wr) begin
      txe_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_fault_flag_q      <= 1'b0;
      mode_fault_flag_seen_q <= 1'b0;
    end else if (mfault) begin
      mode_fault_flag_q <= 1'b1;
    end else if (sr_rd && mode_fault_flag_q) begin
      mode_fault_flag_seen_q <= 1'b1;
    end else if (cr1_wr && mode_fault_flag_seen_q) begin
      mode_fault_flag_q      <= 1'b0;
      mode_fault_flag_seen_q <= 1'b0;
    end
  end

  // Pin drive; mode fault drops the sck and mosi output enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins <= '0;
    end else begin
      pins.sck_o   <= msck_q;
      pins.sck_oe  <= enabled & master & ~mfault;
      if (!msck_q)
        pins.mosi_o <= sh_q[7]; // Moves only while clock low, so the far side latches a settled bit
      pins.mosi_oe <= enabled & master & ~mfault;
      pins.miso_o  <= sh_q[7];
      pins.miso_oe <= enabled & ~master & ss_low;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= (mode_fault_flag_q & cr1_q[SPILP_CR1_MFIE]) | (done_q & cr1_q[SPILP_CR1_DIE]) |
             (txe_q & cr1_q[SPILP_CR1_TEIE]);
  end
endmodule
`default_nettype wire

// >>> spilp_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module spilp_monitor (
  input wire logic                  aclk,          // Clock
  input wire logic                  aresetn,       // Reset
  input wire logic                  s_axi_awvalid, // Aw valid
  input wire logic                  s_axi_awready, // Aw ready
  input wire logic                  s_axi_wvalid,  // W valid
  input wire logic                  s_axi_wready,  // W ready
  input wire logic                  s_axi_bvalid,  // B valid
  input wire logic                  s_axi_bready,  // B ready
  input wire logic [7:0]            s_axi_araddr,  // Ar addr
  input wire logic                  s_axi_arvalid, // Ar valid
  input wire logic                  s_axi_rvalid,  // R valid
  input wire logic                  s_axi_rready,  // R ready
  input wire logic [31:0]           s_axi_rdata,   // R data
  input wire logic [1:0]            s_axi_rresp,   // R resp
  input wire spilp_pkg::spilp_pins_t pins,         // Pins
  input wire logic                  irq            // Irq
);
  import spilp_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  chk_r_lat: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  chk_bad_addr: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr > SPILP_CTRL_OFS
    |=> s_axi_rresp == SPILP_RESP_ERR && s_axi_rdata == 32'h0) else $error("unmapped read answer wrong");
  chk_irq_reset: assert property ($rose(aresetn) |-> !irq)
    else $error("irq set after reset");
  chk_sck_pace: assert property ($changed(pins.sck_o) && pins.sck_oe |=> $stable(pins.sck_o)[*3])
    else $error("serial clock half period short");
  chk_oe_pair: assert property (pins.sck_oe == pins.mosi_oe)
    else $error("clock and data enables differ");
  chk_mosi_hold: assert property (pins.sck_o && $past(pins.sck_o) |-> $stable(pins.mosi_o))
    else $error("data moved while serial clock high");
  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($fell(pins.sck_oe));
endmodule
bind spilp_core spilp_monitor i_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pins, .irq);
`default_nettype wire

// >>> spilp_peer.sv
`timescale 1ns/10ps
`default_nettype none
module spilp_peer (
  input wire logic       sck,     // Serial clock
  input wire logic       mosi,    // From master
  input wire logic [7:0] tx_byte, // Byte returned
  output logic           miso,    // To master
  output logic [7:0]     rx_byte  // Byte seen
);
  logic [2:0] idx = 3'h0;
  initial rx_byte = 8'h00;
  // Next bit goes out after each rising edge; the block samples long before the next one
  assign miso = tx_byte[3'h7 - idx];
  always @(posedge sck) begin
    rx_byte <= {rx_byte[6:0], mosi};
    idx     <= idx + 3'h1;
  end
endmodule
`default_nettype wire

// >>> spilp_tb.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import spilp_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, ss_n_i = 1'b1, miso_i, irq;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mv, s;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, peer_tx = 8'h00, peer_rx;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  spilp_pins_t pins;
  wire         sck_i = pins.sck_oe & pins.sck_o;
  wire         mosi_i = pins.mosi_oe & pins.mosi_o;
  int          error_cnt = 0, n_checks = 0, n;
  always #20 aclk = ~aclk;
  spilp_core i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sck_i, .mosi_i, .miso_i, .ss_n_i, .pins, .irq);
  spilp_peer i_peer (.sck(sck_i), .mosi(mosi_i), .tx_byte(peer_tx), .miso(miso_i), .rx_byte(peer_rx));
  task automatic conclude();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    n = n + 1;
    if (n > k) begin
      error_cnt++;
      $display("Error wait expected answer seen none");
      conclude();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    n = 0;
    @(posedge aclk); // Back-to-back calls never drive one signal twice in a step
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      tick(50);
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      tick(50);
    end while (s_axi_rvalid !== 1'b1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, d);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      rd(SPILP_SR_OFS);
      k++;
      if (k > 100) tick(0);
    end while (d[SPILP_SR_DONE] !== 1'b1);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rc("dr after reset", SPILP_DR_OFS, 32'h0);
    rc("sr after reset", SPILP_SR_OFS, 32'h20);
    rd(8'h40);
    chk("unmapped resp", {30'h0, SPILP_RESP_ERR}, {30'h0, r});
    wr(SPILP_CR1_OFS, 32'hD0);
    peer_tx <= 8'h3C;
    wr(SPILP_DR_OFS, 32'hA5);
    wait_done();
    chk("sr at done", 32'hA0, d);
    chk("irq at done", 32'h1, {31'h0, irq});
    chk("peer rx", 32'hA5, {24'h0, peer_rx});
    peer_tx <= 8'h5A;
    wr(SPILP_DR_OFS, 32'h96);
    repeat (100) @(posedge aclk);
    rc("sr pending", SPILP_SR_OFS, 32'hA0);
    rc("dr kept", SPILP_DR_OFS, 32'h3C);
    repeat (2) @(posedge aclk);
    chk("irq served", 32'h0, {31'h0, irq});
    chk("peer rx second", 32'h96, {24'h0, peer_rx});
    // Wait with stop-on-wait, stop alone, wait without stop-on-wait
    for (int i = 0; i < 3; i++) begin
      wr(SPILP_CR2_OFS, (i == 0) ? 32'h2 : 32'h0);
      peer_tx <= 8'h11 * (i + 1);
      wr(SPILP_DR_OFS, 32'h81 + i);
      repeat (12) @(posedge aclk);
      wr(SPILP_CTRL_OFS, (i == 1) ? 32'h2 : 32'h1);
      s = pins.sck_o;
      mv = 1'b0;
      repeat (40) begin
        @(posedge aclk);
        if (pins.sck_o !== s) mv = 1'b1;
      end
      chk("sck moved", {31'h0, i == 2}, {31'h0, mv});
      wr(SPILP_CTRL_OFS, 32'h0);
      wait_done();
      rc("dr resumed", SPILP_DR_OFS, 32'h11 * (i + 1));
      chk("peer rx resumed", 32'h81 + i, {24'h0, peer_rx});
    end
    wr(SPILP_CR1_OFS, 32'h5C);
    ss_n_i <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("irq fault", 32'h1, {31'h0, irq});
    rc("cr1 after fault", SPILP_CR1_OFS, 32'h4C);
    rc("sr fault", SPILP_SR_OFS, 32'h30);
    ss_n_i <= 1'b1;
    wr(SPILP_CR1_OFS, 32'h4C);
    rc("sr fault cleared", SPILP_SR_OFS, 32'h20);
    chk("irq fault cleared", 32'h0, {31'h0, irq});
    conclude();
  end
endmodule
`default_nettype wire
